// ### flat_panel_pkg.sv
// shared types and constants for the flat panel output stage
package flat_panel_pkg;

  // panel wiring families
  typedef enum logic [2:0] {
    PANEL_MONO_DUAL,
    PANEL_CSTN_SINGLE,
    PANEL_CSTN_DUAL,
    PANEL_TFT_NARROW,
    PANEL_TFT_WIDE,
    PANEL_PLASMA_EL
  } panel_type_t;

  typedef enum logic [2:0] {
    DEPTH_9,
    DEPTH_12,
    DEPTH_16,
    DEPTH_18,
    DEPTH_24
  } tft_depth_t;

  typedef enum logic [1:0] {
    PWR_DARK,
    PWR_LOGIC,
    PWR_BIAS,
    PWR_LIT
  } power_state_t;

  localparam int DATA_W = 24;
  localparam int COLOR_W = 8;
  localparam int INV_W = 8;
  localparam int STEP_W = 16;

  // colour bits kept per component for each depth
  localparam logic [3:0] KEEP_3 = 4'h3;
  localparam logic [3:0] KEEP_4 = 4'h4;
  localparam logic [3:0] KEEP_5 = 4'h5;
  localparam logic [3:0] KEEP_6 = 4'h6;
  localparam logic [3:0] KEEP_8 = 4'h8;

  // power enables after reset: logic and bias on, backlight off
  localparam logic LOGIC_EN_RST = 1'b1;
  localparam logic BIAS_EN_RST = 1'b1;
  localparam logic BACK_EN_RST = 1'b0;
  localparam power_state_t PWR_RST_STATE = PWR_BIAS;

  typedef struct packed {
    logic [COLOR_W-1:0] red;
    logic [COLOR_W-1:0] green;
    logic [COLOR_W-1:0] blue;
  } pixel_t;

  // one pixel group from the video side, taken while ready is high
  typedef struct packed {
    logic valid;
    logic line_end;
    logic frame_begin;
    logic active;
    pixel_t pixel;
  } video_in_t;

  typedef struct packed {
    panel_type_t panel_type;
    tft_depth_t depth;
    logic line_as_de;
    logic inv_as_de;
    logic [INV_W-1:0] inv_lines;
  } link_cfg_t;

  typedef struct packed {
    logic panel_shift_clock;
    logic line_pulse;
    logic frame_start;
    logic ac_invert;
    logic [DATA_W-1:0] data;
  } panel_pins_t;

endpackage : flat_panel_pkg

// ### flat_panel_output.sv
// flat panel output stage: link timing, pin mapping, power sequencing, off pin
`timescale 1ns/1ps

// Notes on behaviour
// - drive shift clock clocking each data group
// - line output: line clock, hsync, or enable
// - frame output starts frame or gives vsync
// - inversion output toggles, or acts as enable
// - TFT colour on 16 or 24 lines, 9/12/16/18/24 bits
// - colour STN upper and lower data bytes
// - gray nibbles upper/lower, plasma odd/even
// - activity flag high on valid access
// - logic power enable, active high, resets 1
// - bias power enable, active high, resets 1
// - backlight enable, active high, resets 0
// - off pin input high enters off mode
// - off pin may output active status
module flat_panel_output #(
  parameter int STEP_W = flat_panel_pkg::STEP_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic video_clk,
  input flat_panel_pkg::video_in_t video_in,
  output logic video_ready,
  output flat_panel_pkg::panel_pins_t panel_out,
  input flat_panel_pkg::link_cfg_t link_cfg,
  input wire logic panel_enable,
  input wire logic [STEP_W-1:0] step_delay,
  output logic panel_logic_power_en,
  output logic panel_bias_power_en,
  output logic panel_backlight_en,
  input wire logic access_valid,
  output logic bus_access_flag,
  input wire logic off_as_output,
  input wire logic off_in,
  output logic off_out,
  output logic off_oe,
  output logic off_mode,
  output flat_panel_pkg::power_state_t power_state
);

  // ---------------- video clock domain ----------------

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    flat_panel_pkg::link_cfg_t cfg_s1;
    flat_panel_pkg::link_cfg_t cfg_s2;
    logic phase;
    logic loaded;
    logic last_line_end;
    logic inv_level;
    logic [flat_panel_pkg::INV_W-1:0] inv_count;
    flat_panel_pkg::panel_pins_t pins;
  } link_state_t;

  link_state_t link_reg;
  link_state_t link_next;

  function automatic logic [3:0] rev4(input logic [3:0] x);
    rev4 = {x[0], x[1], x[2], x[3]};
  endfunction : rev4

  function automatic logic [7:0] rev8(input logic [7:0] x);
    rev8 = {rev4(x[3:0]), rev4(x[7:4])};
  endfunction : rev8

  function automatic logic [7:0] keep_msbs(input logic [7:0] v, input logic [3:0] n);
    keep_msbs = v & ~(8'hFF >> n);
  endfunction : keep_msbs

  // places one pixel group on the 24 data lines for the chosen panel
  function automatic logic [flat_panel_pkg::DATA_W-1:0] map_pixel(
    input flat_panel_pkg::pixel_t p,
    input flat_panel_pkg::link_cfg_t c
  );
    logic [flat_panel_pkg::DATA_W-1:0] d;
    logic [3:0] kr;
    logic [3:0] kg;
    logic [3:0] kb;
    logic [7:0] rm;
    logic [7:0] gm;
    logic [7:0] bm;
    d = '0;
    case (c.depth)
      flat_panel_pkg::DEPTH_9: begin
        kr = flat_panel_pkg::KEEP_3;
        kg = flat_panel_pkg::KEEP_3;
        kb = flat_panel_pkg::KEEP_3;
      end
      flat_panel_pkg::DEPTH_12: begin
        kr = flat_panel_pkg::KEEP_4;
        kg = flat_panel_pkg::KEEP_4;
        kb = flat_panel_pkg::KEEP_4;
      end
      flat_panel_pkg::DEPTH_16: begin
        kr = flat_panel_pkg::KEEP_5;
        kg = flat_panel_pkg::KEEP_6;
        kb = flat_panel_pkg::KEEP_5;
      end
      flat_panel_pkg::DEPTH_18: begin
        kr = flat_panel_pkg::KEEP_6;
        kg = flat_panel_pkg::KEEP_6;
        kb = flat_panel_pkg::KEEP_6;
      end
      default: begin
        kr = flat_panel_pkg::KEEP_8;
        kg = flat_panel_pkg::KEEP_8;
        kb = flat_panel_pkg::KEEP_8;
      end
    endcase
    rm = keep_msbs(p.red, kr);
    gm = keep_msbs(p.green, kg);
    bm = keep_msbs(p.blue, kb);
    case (c.panel_type)
      flat_panel_pkg::PANEL_MONO_DUAL: begin
        d[3:0] = rev4(p.green[3:0]);
        d[7:4] = rev4(p.blue[3:0]);
      end
      flat_panel_pkg::PANEL_CSTN_SINGLE: begin
        d[7:0] = rev8(p.green);
        d[15:8] = rev8(p.blue);
      end
      flat_panel_pkg::PANEL_CSTN_DUAL: begin
        d[3:0] = rev4(p.green[7:4]);
        d[7:4] = rev4(p.blue[7:4]);
        d[11:8] = rev4(p.green[3:0]);
        d[15:12] = rev4(p.blue[3:0]);
      end
      flat_panel_pkg::PANEL_TFT_NARROW: begin
        d[4:0] = bm[7:3];
        d[10:5] = gm[7:2];
        d[15:11] = rm[7:3];
      end
      flat_panel_pkg::PANEL_TFT_WIDE: begin
        d = {rm, gm, bm};
      end
      flat_panel_pkg::PANEL_PLASMA_EL: begin
        d[11:8] = rev4(p.green[3:0]);
        d[15:12] = rev4(p.blue[3:0]);
      end
      default: begin
        d = '0;
      end
    endcase
    map_pixel = d;
  endfunction : map_pixel

  // groups are taken while phase is low, at the edge that drives the shift clock low
  assign video_ready = link_reg.rst_s2 & ~link_reg.phase;

  always_comb begin
    link_next = link_reg;
    link_next.rst_s1 = rstn;
    link_next.rst_s2 = link_reg.rst_s1;
    link_next.cfg_s1 = link_cfg;
    link_next.cfg_s2 = link_reg.cfg_s1;
    if (!link_reg.rst_s2) begin
      link_next.phase = 1'b0;
      link_next.loaded = 1'b0;
      link_next.last_line_end = 1'b0;
      link_next.inv_level = 1'b0;
      link_next.inv_count = '0;
      link_next.pins = '0;
    end else begin
      link_next.phase = ~link_reg.phase;
      if (!link_reg.phase) begin
        link_next.pins.panel_shift_clock = 1'b0;
        link_next.loaded = video_in.valid;
        if (video_in.valid) begin
          link_next.last_line_end = video_in.line_end;
          link_next.pins.data = map_pixel(video_in.pixel, link_reg.cfg_s2);
          // line clock / hsync, or display enable
          link_next.pins.line_pulse = link_reg.cfg_s2.line_as_de ?
            video_in.active : video_in.line_end;
          // held from frame begin through the next line end
          link_next.pins.frame_start = video_in.frame_begin |
            (link_reg.pins.frame_start & ~link_reg.last_line_end);
          if (link_reg.cfg_s2.inv_lines == '0) begin
            if (video_in.frame_begin) begin
              link_next.inv_level = ~link_reg.inv_level;
            end
          end else if (video_in.line_end) begin
            if (link_reg.inv_count == link_reg.cfg_s2.inv_lines - 8'h01) begin
              link_next.inv_count = '0;
              link_next.inv_level = ~link_reg.inv_level;
            end else begin
              link_next.inv_count = link_reg.inv_count + 8'h01;
            end
          end
          link_next.pins.ac_invert = link_reg.cfg_s2.inv_as_de ?
            video_in.active : link_next.inv_level;
        end
      end else begin
        // rising edge in mid-group, only when a group was loaded
        link_next.pins.panel_shift_clock = link_reg.loaded;
      end
    end
  end

  always_ff @(posedge video_clk) begin
    link_reg <= link_next;
  end

  assign panel_out = link_reg.pins;

  // ---------------- system clock domain ----------------

  typedef struct packed {
    logic off_s1;
    logic off_s2;
    logic oe;
    logic access;
    flat_panel_pkg::power_state_t pwr;
    logic [STEP_W-1:0] cnt;
    logic logic_en;
    logic bias_en;
    logic back_en;
  } sys_state_t;

  sys_state_t sys_reg;
  sys_state_t sys_next;
  logic off_request;
  logic want_on;
  logic step_done;

  assign off_request = sys_reg.off_s2 & ~sys_reg.oe;
  assign want_on = panel_enable & ~off_request;
  assign step_done = sys_reg.cnt >= step_delay;

  always_comb begin
    sys_next = sys_reg;
    sys_next.off_s1 = off_in;
    sys_next.off_s2 = sys_reg.off_s1;
    if (!rstn) begin
      sys_next.oe = 1'b0;
      sys_next.access = 1'b0;
      sys_next.pwr = flat_panel_pkg::PWR_RST_STATE;
      sys_next.cnt = '0;
      sys_next.logic_en = flat_panel_pkg::LOGIC_EN_RST;
      sys_next.bias_en = flat_panel_pkg::BIAS_EN_RST;
      sys_next.back_en = flat_panel_pkg::BACK_EN_RST;
    end else begin
      sys_next.oe = off_as_output;
      sys_next.access = access_valid;
      if (sys_reg.cnt != '1) begin
        sys_next.cnt = sys_reg.cnt + STEP_W'(1);
      end
      // one step per delay: up logic, bias, backlight; down reversed
      case (sys_reg.pwr)
        flat_panel_pkg::PWR_DARK: begin
          if (want_on && step_done) begin
            sys_next.pwr = flat_panel_pkg::PWR_LOGIC;
            sys_next.cnt = '0;
          end
        end
        flat_panel_pkg::PWR_LOGIC: begin
          if (step_done) begin
            sys_next.pwr = want_on ? flat_panel_pkg::PWR_BIAS :
              flat_panel_pkg::PWR_DARK;
            sys_next.cnt = '0;
          end
        end
        flat_panel_pkg::PWR_BIAS: begin
          if (step_done) begin
            sys_next.pwr = want_on ? flat_panel_pkg::PWR_LIT :
              flat_panel_pkg::PWR_LOGIC;
            sys_next.cnt = '0;
          end
        end
        flat_panel_pkg::PWR_LIT: begin
          if (!want_on && step_done) begin
            sys_next.pwr = flat_panel_pkg::PWR_BIAS;
            sys_next.cnt = '0;
          end
        end
        default: begin
          sys_next.pwr = flat_panel_pkg::PWR_DARK;
        end
      endcase
      sys_next.logic_en = sys_next.pwr != flat_panel_pkg::PWR_DARK;
      sys_next.bias_en = (sys_next.pwr == flat_panel_pkg::PWR_BIAS) ||
        (sys_next.pwr == flat_panel_pkg::PWR_LIT);
      sys_next.back_en = sys_next.pwr == flat_panel_pkg::PWR_LIT;
    end
  end

  always_ff @(posedge clk) begin
    sys_reg <= sys_next;
  end

  assign panel_logic_power_en = sys_reg.logic_en;
  assign panel_bias_power_en = sys_reg.bias_en;
  assign panel_backlight_en = sys_reg.back_en;
  assign bus_access_flag = sys_reg.access;
  assign off_mode = off_request;
  assign off_oe = sys_reg.oe;
  // active status: panel powered
  assign off_out = sys_reg.logic_en;
  assign power_state = sys_reg.pwr;

endmodule : flat_panel_output

// ### flat_panel_output_monitor.sv
// checker for the flat panel output stage, bound to its ports
`timescale 1ns/1ps
module flat_panel_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic video_clk,
  input flat_panel_pkg::video_in_t video_in,
  input wire logic video_ready,
  input flat_panel_pkg::panel_pins_t panel_out,
  input wire logic access_valid,
  input wire logic bus_access_flag,
  input wire logic panel_logic_power_en,
  input wire logic panel_bias_power_en,
  input wire logic panel_backlight_en,
  input wire logic off_as_output,
  input wire logic off_in,
  input wire logic off_out,
  input wire logic off_oe,
  input wire logic off_mode
);
  property p_sc_pulse;
    @(posedge video_clk) disable iff (!rstn)
    panel_out.panel_shift_clock |=> !panel_out.panel_shift_clock;
  endproperty
  a_sc_pulse: assert property (p_sc_pulse) else $error("shift clock too long");
  property p_sc_take;
    @(posedge video_clk) disable iff (!rstn) video_ready && video_in.valid
    |=> !panel_out.panel_shift_clock ##1 panel_out.panel_shift_clock;
  endproperty
  a_sc_take: assert property (p_sc_take) else $error("shift clock missing");
  property p_data_hold;
    @(posedge video_clk) disable iff (!rstn) panel_out.panel_shift_clock
    |-> $stable({panel_out.data, panel_out.line_pulse, panel_out.frame_start});
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved at shift");
  property p_act;
    @(posedge clk) disable iff (!rstn) $past(rstn) |-> bus_access_flag == $past(access_valid);
  endproperty
  a_act: assert property (p_act) else $error("activity flag wrong");
  property p_rst_logic;
    @(posedge clk) !rstn |=> panel_logic_power_en;
  endproperty
  a_rst_logic: assert property (p_rst_logic) else $error("logic enable reset");
  property p_rst_bias;
    @(posedge clk) !rstn |=> panel_bias_power_en;
  endproperty
  a_rst_bias: assert property (p_rst_bias) else $error("bias enable reset");
  property p_rst_back;
    @(posedge clk) !rstn |=> !panel_backlight_en;
  endproperty
  a_rst_back: assert property (p_rst_back) else $error("backlight reset");
  property p_order_up;
    @(posedge clk) disable iff (!rstn)
    $rose(panel_backlight_en) |-> panel_bias_power_en && panel_logic_power_en;
  endproperty
  a_order_up: assert property (p_order_up) else $error("power up order");
  property p_order_dn;
    @(posedge clk) disable iff (!rstn)
    $fell(panel_logic_power_en) |-> !panel_bias_power_en && !panel_backlight_en;
  endproperty
  a_order_dn: assert property (p_order_dn) else $error("power down order");
  property p_off_in;
    @(posedge clk) disable iff (!rstn) (off_in && !off_as_output) [*3] |-> off_mode;
  endproperty
  a_off_in: assert property (p_off_in) else $error("off mode missed");
  property p_off_out;
    @(posedge clk) disable iff (!rstn) off_oe |-> off_out == panel_logic_power_en;
  endproperty
  a_off_out: assert property (p_off_out) else $error("off pin status");
  c_lit: cover property (@(posedge clk) $rose(panel_backlight_en));
  c_dark: cover property (@(posedge clk) $fell(panel_logic_power_en));
  c_take: cover property (@(posedge video_clk) video_ready && video_in.valid);
endmodule : flat_panel_monitor

bind flat_panel_output flat_panel_monitor mon (.clk(clk), .rstn(rstn), .video_clk(video_clk),
  .video_in(video_in), .video_ready(video_ready), .panel_out(panel_out),
  .access_valid(access_valid), .bus_access_flag(bus_access_flag),
  .panel_logic_power_en(panel_logic_power_en), .panel_bias_power_en(panel_bias_power_en),
  .panel_backlight_en(panel_backlight_en), .off_as_output(off_as_output), .off_in(off_in),
  .off_out(off_out), .off_oe(off_oe), .off_mode(off_mode));

// ### flat_panel_sink.sv
// flat panel model: latches the pins on each shift clock rise
`timescale 1ns/1ps
module flat_panel_sink (
  input flat_panel_pkg::panel_pins_t pins,
  output flat_panel_pkg::panel_pins_t seen,
  output int shifts
);
  int n = 0;
  assign shifts = n;
  always @(posedge pins.panel_shift_clock) begin
    seen <= pins;
    n <= n + 1;
  end
endmodule : flat_panel_sink

// ### flat_panel_output_bench.sv
// self-checking bench for the flat panel output stage
`timescale 1ns/1ps
module flat_panel_output_bench;
  logic clk = 1'b0;
  logic video_clk = 1'b0;
  logic rstn = 1'b0;
  flat_panel_pkg::video_in_t vin = '0;
  flat_panel_pkg::link_cfg_t cfg = '0;
  flat_panel_pkg::panel_pins_t pins, seen;
  flat_panel_pkg::power_state_t pst;
  logic ready, lpe, bpe, bke, flag, oout, ooe, omode;
  logic en = 1'b0, acc = 1'b0, oas = 1'b0, oin = 1'b0;
  logic [15:0] dly = 16'h0002;
  logic [31:0] rnd = 32'h060A9250;
  logic exp_fs = 1'b0, prev_le = 1'b0, exp_inv = 1'b0;
  logic [7:0] inv_cnt = 8'h00;
  int shifts, n_mismatch = 0, checked = 0;
  flat_panel_output DUT (.clk(clk), .rstn(rstn), .video_clk(video_clk), .video_in(vin),
    .video_ready(ready), .panel_out(pins), .link_cfg(cfg), .panel_enable(en),
    .step_delay(dly), .panel_logic_power_en(lpe), .panel_bias_power_en(bpe),
    .panel_backlight_en(bke), .access_valid(acc), .bus_access_flag(flag),
    .off_as_output(oas), .off_in(oin), .off_out(oout), .off_oe(ooe), .off_mode(omode),
    .power_state(pst));
  flat_panel_sink panel (.pins(pins), .seen(seen), .shifts(shifts));
  initial forever #5 clk = ~clk;
  initial begin
    #37;
    forever #80 video_clk = ~video_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // keeps the n most significant bits of a colour component
  function automatic logic [7:0] top(input logic [7:0] x, input logic [3:0] n);
    return x & (8'hFF << (4'h8 - n));
  endfunction : top
  function automatic logic [23:0] exp_map(input logic [2:0] t,
    input flat_panel_pkg::tft_depth_t d, input flat_panel_pkg::pixel_t p);
    logic [7:0] g;
    logic [7:0] b;
    logic [3:0] kr;
    logic [3:0] kg;
    logic [3:0] kb;
    logic [7:0] r;
    logic [7:0] gt;
    logic [7:0] bt;
    g = {<<{p.green}};
    b = {<<{p.blue}};
    case (d)
      flat_panel_pkg::DEPTH_9: {kr, kg, kb} = {3{flat_panel_pkg::KEEP_3}};
      flat_panel_pkg::DEPTH_12: {kr, kg, kb} = {3{flat_panel_pkg::KEEP_4}};
      flat_panel_pkg::DEPTH_16: {kr, kg, kb} = {flat_panel_pkg::KEEP_5,
        flat_panel_pkg::KEEP_6, flat_panel_pkg::KEEP_5};
      flat_panel_pkg::DEPTH_18: {kr, kg, kb} = {3{flat_panel_pkg::KEEP_6}};
      default: {kr, kg, kb} = {3{flat_panel_pkg::KEEP_8}};
    endcase
    r = top(p.red, kr);
    gt = top(p.green, kg);
    bt = top(p.blue, kb);
    case (t)
      3'h0: return {16'h0000, b[7:4], g[7:4]};
      3'h1: return {8'h00, b, g};
      3'h2: return {8'h00, b[7:4], g[7:4], b[3:0], g[3:0]};
      3'h3: return {8'h00, r[7:3], gt[7:2], bt[7:3]};
      3'h4: return {r, gt, bt};
      default: return {8'h00, b[7:4], g[7:4], 8'h00};
    endcase
  endfunction : exp_map
  task automatic end_sim;
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [23:0] got, input logic [23:0] want);
    checked++;
    if (got !== want) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, got, want);
    end
  endtask : chk
  task automatic wait_pst(input flat_panel_pkg::power_state_t s);
    for (int i = 0; i < 300 && pst !== s; i++) @(negedge clk);
    if (pst !== s) begin
      n_mismatch++;
      end_sim();
    end
    chk({lpe, bpe, bke}, {s != flat_panel_pkg::PWR_DARK, s >= flat_panel_pkg::PWR_BIAS,
      s == flat_panel_pkg::PWR_LIT});
  endtask : wait_pst
  task automatic send(input flat_panel_pkg::video_in_t v);
    @(negedge video_clk);
    for (int i = 0; i < 8 && ready !== 1'b1; i++) @(negedge video_clk);
    if (ready !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
    vin = v;
    @(negedge video_clk);
    vin.valid = 1'b0;
    repeat (2) @(negedge video_clk);
  endtask : send
  initial begin
    flat_panel_pkg::video_in_t v;
    int n;
    repeat (50) @(negedge clk);
    chk({lpe, bpe, bke, flag, ooe}, 5'h18);
    rstn = 1'b1;
    repeat (40) begin
      rnd = lfsr(rnd);
      acc = rnd[0];
      @(negedge clk);
      chk(flag, acc);
    end
    acc = 1'b0;
    en = 1'b1;
    wait_pst(flat_panel_pkg::PWR_LIT);
    en = 1'b0;
    wait_pst(flat_panel_pkg::PWR_DARK);
    en = 1'b1;
    wait_pst(flat_panel_pkg::PWR_LIT);
    oas = 1'b1;
    repeat (2) @(negedge clk);
    chk({ooe, oout}, 2'h3);
    oas = 1'b0;
    oin = 1'b1;
    wait_pst(flat_panel_pkg::PWR_DARK);
    chk(omode, 1'b1);
    en = 1'b0;
    oas = 1'b1;
    repeat (3) @(negedge clk);
    chk({ooe, oout, omode}, 3'h4);
    @(negedge video_clk);
    for (int k = 0; k < 18; k++) begin
      rnd = lfsr(rnd);
      cfg.panel_type = flat_panel_pkg::panel_type_t'(3'(k % 6));
      cfg.depth = flat_panel_pkg::tft_depth_t'(3'((k + k / 6) % 5));
      cfg.line_as_de = rnd[0];
      cfg.inv_as_de = rnd[3];
      cfg.inv_lines = k[0] ? 8'h02 : 8'h00;
      repeat (4) @(negedge video_clk);
      for (int g = 0; g < 4; g++) begin
        rnd = lfsr(rnd);
        v = '0;
        v.valid = 1'b1;
        v.frame_begin = (g == 0);
        v.line_end = rnd[1];
        v.active = rnd[2];
        v.pixel = rnd[31:8];
        // frame start holds until the group after a line end
        exp_fs = v.frame_begin | (exp_fs & ~prev_le);
        prev_le = v.line_end;
        // inversion flips per frame, or every inv_lines line ends
        if (cfg.inv_lines == 8'h00) begin
          exp_inv = exp_inv ^ v.frame_begin;
        end else if (v.line_end) begin
          inv_cnt = inv_cnt + 8'h01;
          if (inv_cnt == cfg.inv_lines) begin
            inv_cnt = 8'h00;
            exp_inv = ~exp_inv;
          end
        end
        n = shifts;
        send(v);
        chk(seen.data, exp_map(3'(k % 6), cfg.depth, v.pixel));
        chk(24'(shifts - n), 24'h000001);
        chk(seen.line_pulse, cfg.line_as_de ? v.active : v.line_end);
        chk(seen.ac_invert, cfg.inv_as_de ? v.active : exp_inv);
        chk(seen.frame_start, exp_fs);
      end
    end
    v.valid = 1'b0;
    n = shifts;
    send(v);
    chk(24'(shifts - n), 24'h000000);
    end_sim();
  end
  initial begin
    #900000;
    n_mismatch++;
    end_sim();
  end
endmodule : flat_panel_output_bench
